// ==== hdl/crc_gen_regs.svh ====
// Register offsets, field positions, reset values and depths of the CRC generator.
`ifndef CRC_GEN_REGS_SVH
`define CRC_GEN_REGS_SVH
`define CRC_ADDR_W 4
`define CRC_DATA_W 16
`define CRC_OFS_CONTROL 4'h0
`define CRC_OFS_TERM_MASK 4'h1
`define CRC_OFS_DATA 4'h2
`define CRC_OFS_INPUT 4'h3
`define CRC_BIT_IDLE_STOP 13
`define CRC_FLD_COUNT_HI 12
`define CRC_FLD_COUNT_LO 8
`define CRC_BIT_FULL 7
`define CRC_BIT_EMPTY 6
`define CRC_BIT_GO 4
`define CRC_FLD_LEN_HI 3
`define CRC_FLD_LEN_LO 0
`define CRC_RST_LEN 4'h0
`define CRC_RST_TERM_MASK 16'h0000
`define CRC_RST_DATA 16'h0000
`define CRC_DEPTH_LONG 5'h08
`define CRC_DEPTH_SHORT 5'h10
`define CRC_LONG_LEN_MIN 4'h7
`endif

// ==== hdl/crc_gen_pkg.sv ====
// Types and shared decode functions of the CRC generator.
`include "crc_gen_regs.svh"
package crc_gen_pkg;
	typedef logic [15:0] word_t;
	typedef logic [3:0] len_t;
	typedef logic [4:0] count_t;
	typedef enum logic [1:0] {
		SH_IDLE = 2'b01,
		SH_RUN = 2'b10
	} shift_state_t;

	function automatic count_t fifo_depth(input len_t len);
		if (len > `CRC_LONG_LEN_MIN)
			fifo_depth = `CRC_DEPTH_LONG;
		else
			fifo_depth = `CRC_DEPTH_SHORT;
	endfunction : fifo_depth

	function automatic word_t len_mask(input len_t len);
		len_mask = 16'hffff >> (4'hf - len);
	endfunction : len_mask
endpackage : crc_gen_pkg

// ==== hdl/crc_fifo_mem.sv ====
// Sixteen-word input store of the CRC generator with registered read data.
`timescale 1ns/1ps
module crc_fifo_mem
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic wr_en_i,
	input wire logic [3:0] wr_addr_i,
	input wire crc_gen_pkg::word_t wr_data_i,
	input wire logic [3:0] rd_addr_i,
	output crc_gen_pkg::word_t rd_data_o
);
	import crc_gen_pkg::*;

	word_t mem_q [16];
	word_t rd_data_q;
	word_t rd_data_d;

	// A word written to the address being fetched is passed straight through, so the
	// shifter never sees stale data when it starts on a word written the cycle before.
	always_comb
	begin
		if (wr_en_i && (wr_addr_i == rd_addr_i))
			rd_data_d = wr_data_i;
		else
			rd_data_d = mem_q[rd_addr_i];
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (wr_en_i)
			mem_q[wr_addr_i] <= wr_data_i;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rd_data_q <= 16'h0000;
		else
			rd_data_q <= rd_data_d;
	end

	assign rd_data_o = rd_data_q;
endmodule : crc_fifo_mem

// ==== hdl/crc_shift_engine.sv ====
// Programmable-length serial CRC shift register with masked XOR feedback taps.
`timescale 1ns/1ps
`include "crc_gen_regs.svh"
module crc_shift_engine
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic shift_en_i,
	input wire logic data_bit_i,
	input wire crc_gen_pkg::len_t len_i,
	input wire crc_gen_pkg::word_t term_mask_i,
	input wire logic load_en_i,
	input wire crc_gen_pkg::word_t load_val_i,
	output crc_gen_pkg::word_t crc_o
);
	import crc_gen_pkg::*;

	word_t crc_q;
	word_t crc_d;
	word_t shifted;
	logic feedback;

	assign feedback = data_bit_i ^ crc_q[len_i];
	assign shifted[0] = feedback;

	genvar g;
	generate
		for (g = 1; g < 16; g++)
		begin : g_tap
			assign shifted[g] = crc_q[g - 1] ^ (term_mask_i[g] & feedback);
		end
	endgenerate

	always_comb
	begin
		if (load_en_i)
			crc_d = load_val_i;
		else if (shift_en_i)
			crc_d = shifted;
		else
			crc_d = crc_q;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			crc_q <= `CRC_RST_DATA;
		else
			crc_q <= crc_d;
	end

	// Bits above the configured length hold leftovers and are hidden from software.
	assign crc_o = crc_q & len_mask(len_i);
endmodule : crc_shift_engine

// ==== hdl/crc_generator.sv ====
// Programmable CRC generator with input FIFO, serial shifter and register port.
// Summary of operation
// - Constant term always included; top term implied.
// - FIFO depth 8 if length field above 7.
// - Only low length-plus-one bits feed the CRC.
// - Each data word write increments valid count.
// - Shift while started and count nonzero; decrement per word.
// - One bit per clock cycle.
// - Full at depth, empty at zero.
// - Write while full wraps count, no event.
// - Event exactly when count goes one to zero.
// - Stop-in-idle bit halts the shifter during idle.
// - Sleep freezes the shifter until resumed.
// - Pending event still passed on while stopped.
`timescale 1ns/1ps
`include "crc_gen_regs.svh"
module crc_generator
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire crc_gen_pkg::word_t reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output crc_gen_pkg::word_t reg_rdata_o,
	input wire logic sleep_i,
	input wire logic idle_i,
	output logic crc_event_o
);
	import crc_gen_pkg::*;

	logic idle_stop_bit_q;
	logic idle_stop_bit_d;
	logic shift_start_bit_q;
	logic shift_start_bit_d;
	len_t poly_length_field_q;
	len_t poly_length_field_d;
	word_t poly_term_mask_q;
	word_t poly_term_mask_d;
	logic wr_control;
	logic wr_term_mask;
	logic wr_data;
	logic wr_input;

	logic [3:0] wr_ptr_q;
	logic [3:0] wr_ptr_d;
	logic [3:0] rd_ptr_q;
	logic [3:0] rd_ptr_d;
	count_t valid_word_count_q;
	count_t valid_word_count_d;
	logic [3:0] bit_idx_q;
	logic [3:0] bit_idx_d;
	shift_state_t state_q;
	shift_state_t state_d;
	logic event_q;
	logic event_d;

	word_t rdata_q;
	word_t rdata_d;
	word_t fifo_word;
	word_t crc_value;
	count_t depth;
	logic fifo_full_flag;
	logic fifo_empty_flag;
	logic run_en;
	logic shift_en;
	logic last_bit;
	logic pop;
	logic push;
	logic wrap;

	// Register address decode.
	always_comb
	begin
		wr_control = 1'b0;
		wr_term_mask = 1'b0;
		wr_data = 1'b0;
		wr_input = 1'b0;
		if (reg_wr_i && (reg_addr_i == `CRC_OFS_CONTROL))
			wr_control = 1'b1;
		else if (reg_wr_i && (reg_addr_i == `CRC_OFS_TERM_MASK))
			wr_term_mask = 1'b1;
		else if (reg_wr_i && (reg_addr_i == `CRC_OFS_DATA))
			wr_data = 1'b1;
		else if (reg_wr_i && (reg_addr_i == `CRC_OFS_INPUT))
			wr_input = 1'b1;
	end

	always_comb
	begin
		idle_stop_bit_d = idle_stop_bit_q;
		shift_start_bit_d = shift_start_bit_q;
		poly_length_field_d = poly_length_field_q;
		poly_term_mask_d = poly_term_mask_q;
		if (wr_control)
		begin
			idle_stop_bit_d = reg_wdata_i[`CRC_BIT_IDLE_STOP];
			shift_start_bit_d = reg_wdata_i[`CRC_BIT_GO];
			poly_length_field_d = reg_wdata_i[`CRC_FLD_LEN_HI:`CRC_FLD_LEN_LO];
		end
		if (wr_term_mask)
			poly_term_mask_d = {reg_wdata_i[15:1], 1'b0};
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			idle_stop_bit_q <= 1'b0;
			shift_start_bit_q <= 1'b0;
			poly_length_field_q <= `CRC_RST_LEN;
			poly_term_mask_q <= `CRC_RST_TERM_MASK;
		end
		else
		begin
			idle_stop_bit_q <= idle_stop_bit_d;
			shift_start_bit_q <= shift_start_bit_d;
			poly_length_field_q <= poly_length_field_d;
			poly_term_mask_q <= poly_term_mask_d;
		end
	end

	assign depth = fifo_depth(poly_length_field_q);
	assign fifo_full_flag = (valid_word_count_q == depth);
	assign fifo_empty_flag = (valid_word_count_q == 5'h00);
	assign run_en = !sleep_i && !(idle_i && idle_stop_bit_q);
	assign shift_en = shift_start_bit_q && !fifo_empty_flag && run_en;
	assign last_bit = (bit_idx_q == poly_length_field_q);
	assign pop = shift_en && last_bit;
	assign push = wr_input;
	assign wrap = push && fifo_full_flag;

	always_comb
	begin
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		bit_idx_d = bit_idx_q;
		state_d = state_q;
		if (wrap)
		begin
			wr_ptr_d = 4'h0;
			rd_ptr_d = 4'h0;
			bit_idx_d = 4'h0;
			valid_word_count_d = 5'h00;
			state_d = SH_IDLE;
		end
		else
		begin
			valid_word_count_d = 5'(valid_word_count_q + {4'h0, push} - {4'h0, pop});
			if (push)
				wr_ptr_d = 4'(wr_ptr_q + 4'h1);
			if (pop)
				rd_ptr_d = 4'(rd_ptr_q + 4'h1);
			case (state_q)
				SH_IDLE:
				begin
					if (shift_en && !last_bit)
					begin
						bit_idx_d = 4'(bit_idx_q + 4'h1);
						state_d = SH_RUN;
					end
				end
				SH_RUN:
				begin
					if (pop)
					begin
						bit_idx_d = 4'h0;
						state_d = SH_IDLE;
					end
					else if (shift_en)
						bit_idx_d = 4'(bit_idx_q + 4'h1);
				end
				default:
				begin
					bit_idx_d = 4'h0;
					state_d = SH_IDLE;
				end
			endcase
		end
		event_d = (valid_word_count_q == 5'h01) && (valid_word_count_d == 5'h00) && !wrap;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_q <= 4'h0;
			rd_ptr_q <= 4'h0;
			valid_word_count_q <= 5'h00;
			bit_idx_q <= 4'h0;
			state_q <= SH_IDLE;
			event_q <= 1'b0;
		end
		else
		begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			valid_word_count_q <= valid_word_count_d;
			bit_idx_q <= bit_idx_d;
			state_q <= state_d;
			event_q <= event_d;
		end
	end

	assign crc_event_o = event_q;

	// A word written into a full FIFO is dropped, since the wrap empties it anyway.
	crc_fifo_mem u_fifo_mem
	(
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.wr_en_i(push && !fifo_full_flag),
		.wr_addr_i(wr_ptr_q),
		.wr_data_i(reg_wdata_i & len_mask(poly_length_field_q)),
		.rd_addr_i(rd_ptr_d),
		.rd_data_o(fifo_word)
	);

	// Words are shifted least significant bit first, ending on the bit selected by the length field.
	crc_shift_engine u_engine
	(
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.shift_en_i(shift_en && !wrap),
		.data_bit_i(fifo_word[bit_idx_q]),
		.len_i(poly_length_field_q),
		.term_mask_i(poly_term_mask_q),
		.load_en_i(wr_data),
		.load_val_i(reg_wdata_i),
		.crc_o(crc_value)
	);

	// Read data stands only in the cycle after the read strobe; unmapped reads give zero.
	always_comb
	begin
		rdata_d = 16'h0000;
		if (reg_rd_i && (reg_addr_i == `CRC_OFS_CONTROL))
		begin
			rdata_d[`CRC_BIT_IDLE_STOP] = idle_stop_bit_q;
			rdata_d[`CRC_FLD_COUNT_HI:`CRC_FLD_COUNT_LO] = valid_word_count_q;
			rdata_d[`CRC_BIT_FULL] = fifo_full_flag;
			rdata_d[`CRC_BIT_EMPTY] = fifo_empty_flag;
			rdata_d[`CRC_BIT_GO] = shift_start_bit_q;
			rdata_d[`CRC_FLD_LEN_HI:`CRC_FLD_LEN_LO] = poly_length_field_q;
		end
		else if (reg_rd_i && (reg_addr_i == `CRC_OFS_TERM_MASK))
			rdata_d = poly_term_mask_q;
		else if (reg_rd_i && (reg_addr_i == `CRC_OFS_DATA))
			rdata_d = crc_value;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_q <= 16'h0000;
		else
			rdata_q <= rdata_d;
	end

	assign reg_rdata_o = rdata_q;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_last_word_out;
		(valid_word_count_q == 5'h01) && pop && !push;
	endsequence

	sequence s_event_seen;
		crc_event_o && fifo_empty_flag;
	endsequence
	property p_event_on_drain;
		s_last_word_out |=> s_event_seen;
	endproperty
	a_event_on_drain: assert property (p_event_on_drain) else $error("no event on drain");
	property p_event_cause;
		crc_event_o |-> ($past(valid_word_count_q) == 5'h01) && fifo_empty_flag;
	endproperty
	a_event_cause: assert property (p_event_cause) else $error("spurious event");
	property p_wrap_empty;
		(push && fifo_full_flag) |=> fifo_empty_flag && !crc_event_o;
	endproperty
	a_wrap_empty: assert property (p_wrap_empty) else $error("full write did not wrap");
	property p_push_counts;
		(push && !fifo_full_flag && !pop) |=> (valid_word_count_q == 5'($past(valid_word_count_q) + 5'h01));
	endproperty
	a_push_counts: assert property (p_push_counts) else $error("write not counted");
	property p_depth_bound;
		valid_word_count_q <= fifo_depth(poly_length_field_q) || $changed(poly_length_field_q);
	endproperty
	a_depth_bound: assert property (p_depth_bound) else $error("count above depth");
	property p_stopped_holds;
		(!shift_start_bit_q && !push) |=> $stable(valid_word_count_q) && $stable(bit_idx_q);
	endproperty
	a_stopped_holds: assert property (p_stopped_holds) else $error("shifter ran while stopped");
	property p_sleep_freeze;
		(sleep_i && !push && !wr_data) |=> $stable(bit_idx_q) && $stable(crc_value) && $stable(rd_ptr_q);
	endproperty
	a_sleep_freeze: assert property (p_sleep_freeze) else $error("state moved in sleep");
	property p_bit_per_cycle;
		(shift_en && !last_bit && !wrap) |=> (bit_idx_q == 4'($past(bit_idx_q) + 4'h1));
	endproperty
	a_bit_per_cycle: assert property (p_bit_per_cycle) else $error("shifter skipped a bit");
	property p_control_read;
		(reg_rd_i && (reg_addr_i == `CRC_OFS_CONTROL)) |=>
			(reg_rdata_o[12:8] == $past(valid_word_count_q)) && (reg_rdata_o[6] == $past(fifo_empty_flag));
	endproperty
	a_control_read: assert property (p_control_read) else $error("control readback wrong");
endmodule : crc_generator

// ==== verif/tb_top.sv ====
// Self-checking testbench of the CRC generator through its register port.
`timescale 1ns/1ps
module tb_top;
import crc_gen_pkg::*;
logic clk_sys_i = 1'b0;
logic rst_n_i = 1'b0;
logic [3:0] reg_addr_i = 4'h0;
word_t reg_wdata_i = 16'h0000;
logic reg_wr_i = 1'b0;
logic reg_rd_i = 1'b0;
logic sleep_i = 1'b0;
logic idle_i = 1'b0;
word_t reg_rdata_o;
logic crc_event_o;
int error_cnt = 0;
int num_checks = 0;
int ev_cnt = 0;
int cyc = 0;

crc_generator crc_generator_i (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.sleep_i(sleep_i),
	.idle_i(idle_i),
	.crc_event_o(crc_event_o)
);

always #2 clk_sys_i = ~clk_sys_i;

// The whole run needs a few hundred cycles, so a hang is cut well above that.
always @(posedge clk_sys_i)
begin
	cyc++;
	if (crc_event_o === 1'b1)
		ev_cnt++;
	if (cyc == 20000)
	begin
		error_cnt++;
		conclude();
	end
end

task conclude;
	$display("Checks %0d, errors %0d", num_checks, error_cnt);
	if (error_cnt == 0 && num_checks > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask : conclude

task chk_w(input string n, input word_t e, input word_t g);
	num_checks++;
	if (g !== e)
	begin
		error_cnt++;
		$display("MISMATCH %s expected %h seen %h", n, e, g);
	end
endtask : chk_w

task chk_i(input string n, input int e, input int g);
	num_checks++;
	if (g != e)
	begin
		error_cnt++;
		$display("MISMATCH %s expected %0d seen %0d", n, e, g);
	end
endtask : chk_i

task wr(input logic [3:0] a, input word_t d);
	@(posedge clk_sys_i);
	reg_addr_i <= a;
	reg_wdata_i <= d;
	reg_wr_i <= 1'b1;
	@(posedge clk_sys_i);
	reg_wr_i <= 1'b0;
endtask : wr

// Read data stand only in the cycle after the strobe, so they are sampled there.
task rd(input logic [3:0] a, input word_t e, input string n);
	@(posedge clk_sys_i);
	reg_addr_i <= a;
	reg_rd_i <= 1'b1;
	@(posedge clk_sys_i);
	reg_rd_i <= 1'b0;
	#1;
	chk_w(n, e, reg_rdata_o);
endtask : rd

function automatic word_t ctl(input logic [4:0] c, input logic f, input logic e, input logic g, input len_t l,
	input logic s);
	ctl = {2'b00, s, c, f, e, 1'b0, g, l};
endfunction : ctl

function automatic word_t crc_model(input word_t c, input word_t d, input len_t l, input word_t m);
	logic fb;
	for (int i = 0; i <= l; i++)
	begin
		fb = d[i] ^ c[l];
		c = {c[14:0], fb} ^ ((m & 16'hfffe) & {16{fb}});
	end
	crc_model = c & (16'hffff >> (4'hf - l));
endfunction : crc_model

task t_reset;
	rd(4'h0, 16'h0040, "control reset");
	@(posedge clk_sys_i);
	#1;
	chk_w("read data idle", 16'h0000, reg_rdata_o);
	rd(4'h1, 16'h0000, "term mask reset");
	rd(4'h2, 16'h0000, "crc data reset");
	rd(4'h3, 16'h0000, "input word read");
	rd(4'h9, 16'h0000, "unmapped read");
endtask : t_reset

task t_regs;
	wr(4'h0, 16'hffff);
	rd(4'h0, 16'h205f, "control access");
	wr(4'h1, 16'hffff);
	rd(4'h1, 16'hfffe, "term mask access");
	wr(4'h0, 16'h0000);
	wr(4'h1, 16'h0000);
endtask : t_regs

// With the shifter stopped the count only climbs, so fullness and wrap are seen exactly.
task t_fill(input len_t l, input int depth);
	int e0;
	e0 = ev_cnt;
	wr(4'h0, {12'h000, l});
	for (int i = 0; i < depth - 1; i++)
		wr(4'h3, 16'h1234);
	repeat (5) @(posedge clk_sys_i);
	rd(4'h0, ctl(5'(depth - 1), 1'b0, 1'b0, 1'b0, l, 1'b0), "below full");
	wr(4'h3, 16'h1234);
	rd(4'h0, ctl(5'(depth), 1'b1, 1'b0, 1'b0, l, 1'b0), "full");
	wr(4'h3, 16'h1234);
	rd(4'h0, ctl(5'h00, 1'b0, 1'b1, 1'b0, l, 1'b0), "wrapped");
	chk_i("wrap events", e0, ev_cnt);
endtask : t_fill

task t_shift(input len_t l, input word_t m, input word_t seed, input word_t d);
	int n;
	int e0;
	word_t lm;
	lm = 16'hffff >> (4'hf - l);
	wr(4'h0, {12'h000, l});
	wr(4'h1, m);
	wr(4'h2, seed);
	rd(4'h2, seed & lm, "crc preset");
	wr(4'h0, {11'h000, 1'b1, l});
	e0 = ev_cnt;
	wr(4'h3, d);
	n = 0;
	do
	begin
		@(posedge clk_sys_i);
		#1;
		n++;
	end while (crc_event_o !== 1'b1 && n < 100);
	chk_i("shift cycles", l + 1, n);
	rd(4'h0, ctl(5'h00, 1'b0, 1'b1, 1'b1, l, 1'b0), "drained");
	rd(4'h2, crc_model(seed & lm, d, l, m), "crc result");
	chk_i("drain events", e0 + 1, ev_cnt);
endtask : t_shift

// Back-to-back words overlap a push with the shifting of the first word.
task t_two;
	int e0;
	wr(4'h2, 16'h0000);
	e0 = ev_cnt;
	wr(4'h3, 16'h0031);
	wr(4'h3, 16'h00c6);
	repeat (24) @(posedge clk_sys_i);
	chk_i("two word events", e0 + 1, ev_cnt);
	rd(4'h2, crc_model(crc_model(16'h0000, 16'h0031, 4'h7, 16'h00e0), 16'h00c6, 4'h7, 16'h00e0),
		"two word crc");
endtask : t_two

task t_freeze(input logic slp, input logic stop, input int mid);
	int e0;
	wr(4'h0, 16'h0007);
	wr(4'h3, 16'h00aa);
	e0 = ev_cnt;
	@(posedge clk_sys_i);
	sleep_i <= slp;
	idle_i <= !slp;
	wr(4'h0, {2'b00, stop, 8'h00, 1'b1, 4'h7});
	repeat (20) @(posedge clk_sys_i);
	chk_i("frozen events", e0 + mid, ev_cnt);
	sleep_i <= 1'b0;
	idle_i <= 1'b0;
	repeat (20) @(posedge clk_sys_i);
	chk_i("resumed events", e0 + 1, ev_cnt);
	rd(4'h0, ctl(5'h00, 1'b0, 1'b1, 1'b1, 4'h7, stop), "resumed control");
endtask : t_freeze

// A one-bit word drains in one cycle, so its event is already pending when idle stops the module.
task t_pending;
	int e0;
	wr(4'h0, 16'h2010);
	e0 = ev_cnt;
	wr(4'h3, 16'h0001);
	@(posedge clk_sys_i);
	idle_i <= 1'b1;
	#1;
	chk_i("event while stopped", 1, crc_event_o);
	repeat (2) @(posedge clk_sys_i);
	idle_i <= 1'b0;
	chk_i("pending events", e0 + 1, ev_cnt);
	rd(4'h0, 16'h2050, "stopped control");
	wr(4'h0, 16'h0000);
endtask : t_pending

initial
begin
	repeat (3) @(posedge clk_sys_i);
	rst_n_i <= 1'b1;
	t_reset();
	t_regs();
	t_fill(4'h7, 16);
	t_fill(4'h8, 8);
	t_shift(4'h3, 16'h0002, 16'h0000, 16'hfff9);
	t_shift(4'h7, 16'h00e0, 16'h0005, 16'h0053);
	t_shift(4'h8, 16'h0110, 16'h00ff, 16'h0155);
	t_shift(4'hf, 16'h1020, 16'hffff, 16'h1234);
	wr(4'h0, 16'h0017);
	wr(4'h1, 16'h00e0);
	t_two();
	t_freeze(1'b1, 1'b0, 0);
	t_freeze(1'b0, 1'b1, 0);
	t_freeze(1'b0, 1'b0, 1);
	t_pending();
	conclude();
end
endmodule : tb_top
